// File: logic/rtcc_control.sv
/*
 * Control and status register set of a battery-backed real-time clock: leap counter,
 * 12/24 hour mode, run control, oscillator failure, standby interrupt handling, periodic,
 * alarm and power-fail interrupts, multi-function output and snapshot control.
 * Assumes the counter chain, compare bytes and oscillator supervision sit outside and
 * deliver synchronous pulses and levels on clk; the processor port is synchronous too.
 */
`timescale 1ns/100ps

module rtcc_control
   import rtcc_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               nrst,
   input  wire logic               cs_n,
   input  wire logic               rd_n,
   input  wire logic               wr_n,
   input  wire logic [ADDR_W-1:0]  addr,
   input  wire logic [DATA_W-1:0]  data_in,
   output logic      [DATA_W-1:0]  data_out,
   output logic                    data_oe,
   input  wire logic [N_PER-1:0]   rollover,
   input  wire logic               year_end,
   input  wire logic [N_PER-1:0]   compare_match,
   input  wire logic               compare_strobe,
   input  wire logic               power_loss_input,
   input  wire logic               standby,
   input  wire logic               osc_running,
   input  wire logic               osc_wave,
   output logic      [1:0]         leap_count,
   output logic                    feb29_allowed,
   output logic                    hour_12_mode,
   output logic                    run_enable,
   output logic                    single_supply,
   output logic                    test_mode,
   output logic                    snapshot_track,
   output logic                    irq_out_n,
   output logic                    multi_function_output,
   output logic                    mfo_oe
);

   typedef struct packed {
      logic              rd_q;
      logic              wr_q;
      logic              sel_q;
      logic [4:0]        addr_q;
      logic [7:0]        wdata_q;
      logic              standby_q;
      logic              osc_q;
      logic              loss_q;
      logic [7:0]        main_q;
      logic              osc_fail_q;
      logic              single_q;
      logic              test_q;
      logic [7:0]        snap_q;
      logic [7:0]        mode_q;
      logic [7:0]        out_sel_q;
      logic [7:0]        per_en_q;
      logic [7:0]        ap_en_q;
      logic              feb29_q;
      logic [7:0]        dout_q;
      logic              doe_q;
      logic              irq_n_q;
      logic              mfo_q;
      logic              mfo_oe_q;
   } rtcc_state_type;

   rtcc_state_type     s_q;
   rtcc_state_type     s_d;
   logic [N_PER-1:0]   roll_flags;
   logic [N_PER-1:0]   roll_clr;

   // ---------------------------------------------------------------------------------------
   // Rollover flags.
   // ---------------------------------------------------------------------------------------
   // The flags set on every rollover whatever the enables, so they work as change flags.
   rtcc_flag_bank #(
      .W     (N_PER)
   ) u_roll_flags (
      .clk   (clk),
      .nrst  (nrst),
      .set   (rollover),
      .clr   (roll_clr),
      .flags (roll_flags)
   );

   // ---------------------------------------------------------------------------------------
   // Next-state logic.
   // ---------------------------------------------------------------------------------------
   logic             wr_done;
   logic             rd_done;
   logic             blk1;
   logic             stby_enter;
   logic             stby_clear;
   logic             osc_fail_evt;
   logic             alarm_hit;
   logic             irq_gate;
   logic [1:0]       ap_eff;
   logic             irq_out_n_level;
   logic             mfo_irq;
   logic [7:0]       rdata;

   // Strobe ends are found from the sampled previous levels; address and data are the
   // values captured while the strobe was low, so they may change as the strobe rises.
   always_comb begin
      s_d          = s_q;
      wr_done      = !s_q.wr_q && wr_n && s_q.sel_q;
      rd_done      = !s_q.rd_q && rd_n && s_q.sel_q;
      blk1         = s_q.main_q[MS_BLOCK_SEL];
      stby_enter   = standby && !s_q.standby_q;
      stby_clear   = stby_enter && !s_q.mode_q[RC_STANDBY_IRQ];
      osc_fail_evt = s_q.osc_q && !osc_running;
      s_d.rd_q      = rd_n;
      s_d.wr_q      = wr_n;
      s_d.standby_q = standby;
      s_d.osc_q     = osc_running;
      s_d.loss_q    = power_loss_input;

      // Capture of the access while a strobe is low.
      if (!rd_n || !wr_n) begin
         s_d.sel_q   = !cs_n;
         s_d.addr_q  = addr;
         s_d.wdata_q = data_in;
      end

      // Flags clear at the end of a read of the rollover register, or on standby entry with the standby bit clear.
      // Only the flags shown by the last captured read data are cleared. A rollover that
      // sets its flag at or after the last capture edge of the strobe therefore survives for the next read.
      roll_clr = ({N_PER{rd_done && !blk1 && s_q.addr_q == OFF_ROLLOVER}}
                  & s_q.dout_q[N_PER-1:0])
                 | {N_PER{stby_clear}};

      // Register writes.
      if (wr_done) begin
         if (s_q.addr_q == OFF_MAIN_STATUS) begin
            s_d.main_q = (s_q.main_q & ~MAIN_RAM_MASK) | (s_q.wdata_q & MAIN_RAM_MASK);
            s_d.main_q[MS_ALARM]    = s_q.main_q[MS_ALARM] & ~s_q.wdata_q[MS_ALARM];
            s_d.main_q[MS_PERIODIC] = s_q.main_q[MS_PERIODIC] & ~s_q.wdata_q[MS_PERIODIC];
         end else if (!blk1 && s_q.addr_q == OFF_ROLLOVER) begin
            s_d.test_q = s_q.wdata_q[RF_TEST_MODE];
            // Battery-backed mode is refused while the oscillator fail flag stands.
            if (s_q.wdata_q[RF_OSC_FAIL] || !s_q.osc_fail_q) begin
               s_d.single_q = s_q.wdata_q[RF_OSC_FAIL];
            end
         end else if (!blk1 && s_q.addr_q == OFF_SNAPSHOT) begin
            s_d.snap_q = s_q.wdata_q;
            s_d.snap_q[SC_NA_BIT] = 1'b0;
         end else if (blk1 && s_q.addr_q == OFF_RUN_CONTROL) begin
            s_d.mode_q = s_q.wdata_q;
            // The run bit only takes a one while the crystal is really oscillating.
            s_d.mode_q[RC_RUN] = s_q.wdata_q[RC_RUN] && osc_running;
            if (s_q.wdata_q[RC_RUN] && osc_running) begin
               s_d.osc_fail_q = 1'b0;
            end
         end else if (blk1 && s_q.addr_q == OFF_OUTPUT_SELECT) begin
            s_d.out_sel_q = s_q.wdata_q;
         end else if (blk1 && s_q.addr_q == OFF_PERIODIC_EN) begin
            s_d.per_en_q = s_q.wdata_q;
         end else if (blk1 && s_q.addr_q == OFF_ALARM_PWR_EN) begin
            s_d.ap_en_q = s_q.wdata_q;
         end
      end

      // Leap counter steps at the end of the year, only while the chain runs.
      if (year_end && s_q.mode_q[RC_RUN]) begin
         s_d.mode_q[1:0] = s_d.mode_q[1:0] + 2'h1;
      end
      s_d.feb29_q = (s_d.mode_q[1:0] == LEAP_THIS_YEAR);

      // Oscillator failure stops the clock and forces single-supply referencing.
      if (osc_fail_evt) begin
         s_d.mode_q[RC_RUN] = 1'b0;
         s_d.osc_fail_q     = 1'b1;
         s_d.single_q       = 1'b1;
      end

      // Standby entry without the standby bit clears both interrupt enable bytes and the periodic status bit.
      if (stby_clear) begin
         s_d.per_en_q = RESET_BYTE;
         s_d.ap_en_q  = RESET_BYTE;
         s_d.main_q[MS_PERIODIC] = 1'b0;
      end

      // Power failure freezes the snapshot bytes by dropping the tracking bit.
      if (power_loss_input && !s_q.loss_q) begin
         s_d.snap_q[SC_TRACK] = 1'b0;
      end

      // Alarm: a disabled comparator counts as equal; with none enabled there is no alarm.
      alarm_hit = compare_strobe && (|s_q.ap_en_q[N_PER-1:0])
                  && (&(compare_match | ~s_q.ap_en_q[N_PER-1:0]));

      // Status set events come after clears so a coincident event wins.
      if (alarm_hit) begin
         s_d.main_q[MS_ALARM] = 1'b1;
      end
      if (|(rollover & s_q.per_en_q[N_PER-1:0])) begin
         s_d.main_q[MS_PERIODIC] = 1'b1;
      end

      // In standby the standby bit gates every interrupt source on to the pins.
      irq_gate = !standby || s_q.mode_q[RC_STANDBY_IRQ];
      ap_eff   = s_q.ap_en_q[AP_POWER_EN:AP_ALARM_EN] & {2{irq_gate}};
      mfo_irq  = power_loss_input && ap_eff[1] && !s_q.out_sel_q[OS_MFO_OSC];
      irq_out_n_level = (s_q.main_q[MS_PERIODIC] && irq_gate)
                   || (s_q.main_q[MS_ALARM] && ap_eff[0])
                   || (power_loss_input && ap_eff[1] && s_q.out_sel_q[OS_MFO_OSC]);
      s_d.irq_n_q = !irq_out_n_level;

      // Multi-function output: power-fail interrupt (active low) or the oscillator wave.
      s_d.mfo_q    = s_q.out_sel_q[OS_MFO_OSC] ? osc_wave : !mfo_irq;
      s_d.mfo_oe_q = !standby || !s_d.mfo_q;

      // The summary bit is rebuilt from the registered pin levels, so it lags the status
      // bits by one cycle; a poll right after a clear may still show it set.
      // Read multiplexer; unmapped offsets read as zero.
      rdata = RESET_BYTE;
      if (addr == OFF_MAIN_STATUS) begin
         rdata = s_q.main_q;
         rdata[MS_POWER_FAIL]  = power_loss_input;
         rdata[MS_IRQ_PENDING] = !s_q.irq_n_q
                                 || (!s_q.out_sel_q[OS_MFO_OSC] && !s_q.mfo_q);
      end else if (!blk1 && addr == OFF_ROLLOVER) begin
         rdata = {s_q.test_q, s_q.osc_fail_q, roll_flags};
      end else if (!blk1 && addr == OFF_SNAPSHOT) begin
         rdata = s_q.snap_q;
      end else if (blk1 && addr == OFF_RUN_CONTROL) begin
         rdata = s_q.mode_q;
      end else if (blk1 && addr == OFF_OUTPUT_SELECT) begin
         rdata = s_q.out_sel_q;
      end else if (blk1 && addr == OFF_PERIODIC_EN) begin
         rdata = s_q.per_en_q;
      end else if (blk1 && addr == OFF_ALARM_PWR_EN) begin
         rdata = s_q.ap_en_q;
      end
      s_d.doe_q = !cs_n && !rd_n;
      if (!cs_n && !rd_n) begin
         s_d.dout_q = rdata;
      end
   end

   // ---------------------------------------------------------------------------------------
   // State register.
   // ---------------------------------------------------------------------------------------
   // Reset stands for first power-up: oscillator fail and single supply set, clock stopped.
   // Strobe edge detectors reset to the idle level of their pins, so no false edge follows.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         s_q            <= '0;
         s_q.rd_q       <= 1'b1;
         s_q.wr_q       <= 1'b1;
         s_q.osc_fail_q <= 1'b1;
         s_q.single_q   <= 1'b1;
         s_q.feb29_q    <= 1'b1;
         s_q.irq_n_q    <= 1'b1;
         s_q.mfo_q      <= 1'b1;
         s_q.mfo_oe_q   <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------------------------------
   // Outputs, all straight from the state register.
   // ---------------------------------------------------------------------------------------
   assign data_out              = s_q.dout_q;
   assign data_oe               = s_q.doe_q;
   assign leap_count            = s_q.mode_q[1:0];
   assign feb29_allowed         = s_q.feb29_q;
   assign hour_12_mode          = s_q.mode_q[RC_HOUR_12];
   assign run_enable            = s_q.mode_q[RC_RUN];
   assign single_supply         = s_q.single_q;
   assign test_mode             = s_q.test_q;
   assign snapshot_track        = s_q.snap_q[SC_TRACK];
   assign irq_out_n             = s_q.irq_n_q;
   assign multi_function_output = s_q.mfo_q;
   assign mfo_oe                = s_q.mfo_oe_q;

endmodule

// File: logic/rtcc_pkg.sv
/*
 * Shared constants of the real-time clock control and status block: register offsets,
 * register block numbers, bit positions and reset values.
 * Assumes a byte-wide parallel register port with a five-bit address.
 */
package rtcc_pkg;

   // ---------------------------------------------------------------------------------------
   // Bus geometry.
   // ---------------------------------------------------------------------------------------
   localparam int        ADDR_W = 5;
   localparam int        DATA_W = 8;
   localparam int        N_PER  = 6;   // Periodic sources and compare bytes.

   // ---------------------------------------------------------------------------------------
   // Register offsets; block 0 or 1 is chosen by the block selector bit.
   // ---------------------------------------------------------------------------------------
   localparam logic [4:0] OFF_MAIN_STATUS   = 5'h00;  // Present in every block.
   localparam logic [4:0] OFF_ROLLOVER      = 5'h03;  // Block 0.
   localparam logic [4:0] OFF_SNAPSHOT      = 5'h04;  // Block 0.
   localparam logic [4:0] OFF_RUN_CONTROL   = 5'h01;  // Block 1.
   localparam logic [4:0] OFF_OUTPUT_SELECT = 5'h02;  // Block 1.
   localparam logic [4:0] OFF_PERIODIC_EN   = 5'h03;  // Block 1.
   localparam logic [4:0] OFF_ALARM_PWR_EN  = 5'h04;  // Block 1.

   // ---------------------------------------------------------------------------------------
   // Bit positions.
   // ---------------------------------------------------------------------------------------
   localparam int        MS_IRQ_PENDING   = 0;
   localparam int        MS_POWER_FAIL    = 1;
   localparam int        MS_PERIODIC      = 2;
   localparam int        MS_ALARM         = 3;
   localparam int        MS_BLOCK_SEL     = 6;
   localparam int        RF_OSC_FAIL      = 6;
   localparam int        RF_TEST_MODE     = 7;
   localparam int        SC_NA_BIT        = 6;
   localparam int        SC_TRACK         = 7;
   localparam int        RC_HOUR_12       = 2;
   localparam int        RC_RUN           = 3;
   localparam int        RC_STANDBY_IRQ   = 4;
   localparam int        OS_MFO_OSC       = 7;
   localparam int        AP_ALARM_EN      = 6;
   localparam int        AP_POWER_EN      = 7;

   // ---------------------------------------------------------------------------------------
   // Reset values and masks.
   // ---------------------------------------------------------------------------------------
   localparam logic [7:0] MAIN_RAM_MASK     = 8'hf0;  // Bits 7..4 are stored as written; bit 6 of them is the block selector.
   localparam logic [7:0] RESET_BYTE        = 8'h00;
   localparam logic [1:0] LEAP_THIS_YEAR    = 2'h0;

endpackage

// File: logic/rtcc_flag_bank.sv
/*
 * Bank of sticky event flags: each flag sets on a one-cycle event pulse and clears on a
 * one-cycle clear pulse; an event in the clearing cycle keeps the flag set.
 * Assumes set and clear pulses are synchronous to clk.
 */
`timescale 1ns/100ps

module rtcc_flag_bank #(
   parameter int W = 6
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] set,
   input  wire logic [W-1:0] clr,
   output logic      [W-1:0] flags
);

   typedef struct packed {
      logic [W-1:0] flag;
   } rtcc_bank_type;

   rtcc_bank_type s_q;
   rtcc_bank_type s_d;

   // ----------------------------------------------------------------------------------------
   // Per-bit update.
   // ----------------------------------------------------------------------------------------
   // Set is applied after clear so a coincident event is never lost.
   always_comb begin
      s_d = s_q;
      for (int i = 0; i < W; i++) begin
         s_d.flag[i] = (s_q.flag[i] & ~clr[i]) | set[i];
      end
   end

   // Register of the bank.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign flags = s_q.flag;

endmodule

// File: testbench/rtcc_control_checker.sv
/* Port checks for the control block.
   Assumes one clock domain and a synchronous active-low reset. */
`timescale 1ns/100ps
module rtcc_control_checker
   import rtcc_pkg::*;
(
   input wire logic              clk,
   input wire logic              nrst,
   input wire logic              cs_n,
   input wire logic              rd_n,
   input wire logic              wr_n,
   input wire logic [DATA_W-1:0] data_out,
   input wire logic              data_oe,
   input wire logic              year_end,
   input wire logic              power_loss_input,
   input wire logic              standby,
   input wire logic              osc_running,
   input wire logic [1:0]        leap_count,
   input wire logic              feb29_allowed,
   input wire logic              run_enable,
   input wire logic              snapshot_track,
   input wire logic              multi_function_output,
   input wire logic              mfo_oe
);
   // ------------------------------------------
   // Properties
   // ------------------------------------------
   // All checks share the port clock and its reset.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   a_oe_follow_read: assert property (!cs_n && !rd_n |=> data_oe)
      else $error("read strobe did not enable the data drive");
   a_oe_release: assert property (cs_n || rd_n |=> !data_oe)
      else $error("data drive kept after the read strobe");
   a_data_hold: assert property (cs_n || rd_n |=> $stable(data_out))
      else $error("read data changed without a read");
   a_leap_step: assert property (year_end && run_enable && !(wr_n && !$past(wr_n))
      |=> leap_count == $past(leap_count) + 2'h1)
      else $error("leap counter did not step at year end");
   a_leap_quiet: assert property (!year_end && wr_n && $past(wr_n) |=> $stable(leap_count))
      else $error("leap counter moved without cause");
   a_feb29_leap: assert property (feb29_allowed == (leap_count == 2'h0))
      else $error("leap day gate disagrees with the counter");
   a_run_needs_osc: assert property (!osc_running |=> !run_enable)
      else $error("counters enabled without a running oscillator");
   a_snap_pf_clear: assert property ($rose(power_loss_input) |=> !snapshot_track)
      else $error("snapshot tracking not stopped by power loss");
   a_mfo_open_drain: assert property (standby && $past(standby)
      && multi_function_output |-> !mfo_oe)
      else $error("output driven high in standby");

   // Main scenarios reached.
   c_leap_step: cover property (year_end && run_enable);
   c_standby_high: cover property (standby && multi_function_output);
   c_power_loss: cover property ($rose(power_loss_input));
endmodule

// File: testbench/rtcc_cpu_model.sv
/* Processor model for the register port: byte reads and writes as tasks.
   Assumes the bench calls the tasks from a single process. */
`timescale 1ns/100ps
module rtcc_cpu_model
   import rtcc_pkg::*;
(
   input  wire logic              clk,
   input  wire logic [DATA_W-1:0] data_out,
   input  wire logic              data_oe,
   output logic                   cs_n,
   output logic                   rd_n,
   output logic                   wr_n,
   output logic      [ADDR_W-1:0] addr,
   output logic      [DATA_W-1:0] data_in
);
   // Idle bus; address and data are inverted on release so stale values never pass.
   initial begin
      cs_n = 1'h1;
      rd_n = 1'h1;
      wr_n = 1'h1;
      addr = '0;
      data_in = '0;
   end

   // Write: strobe low for one edge, the commit edge follows the release.
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      cs_n <= 1'h0;
      wr_n <= 1'h0;
      addr <= a;
      data_in <= d;
      @(posedge clk);
      cs_n <= 1'h1;
      wr_n <= 1'h1;
      addr <= ~a;
      data_in <= ~d;
      @(posedge clk);
   endtask

   // Read: data is taken at the edge that ends the cycle after the strobe is seen.
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic oe);
      @(posedge clk);
      cs_n <= 1'h0;
      rd_n <= 1'h0;
      addr <= a;
      @(posedge clk);
      @(posedge clk);
      d = data_out;
      oe = data_oe;
      cs_n <= 1'h1;
      rd_n <= 1'h1;
      addr <= ~a;
   endtask
endmodule

// File: testbench/rtcc_control_tb.sv
/* Self-checking bench for the control block: events driven here, registers via the
   processor model. Assumes the package is compiled first. */
`timescale 1ns/100ps
module rtcc_control_tb;
   import rtcc_pkg::*;
   // ------------------------------------------
   // Signals
   // ------------------------------------------
   logic              clk = 1'h0;
   logic              nrst = 1'h0;
   logic              cs_n, rd_n, wr_n, data_oe, oe;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] data_in, data_out, rv;
   logic [N_PER-1:0]  rollover = '0, compare_match = '0;
   logic              year_end = 1'h0, compare_strobe = 1'h0, power_loss_input = 1'h0;
   logic              standby = 1'h0, osc_running = 1'h0, osc_wave = 1'h0;
   logic [1:0]        leap_count, lp;
   logic              feb29_allowed, hour_12_mode, run_enable, single_supply, test_mode;
   logic              snapshot_track, irq_out_n, multi_function_output, mfo_oe;
   int                err_count = 0, comparisons = 0, cycles = 0;
   // Alarm cases: enables, raw matches and the main status expected after a strobe.
   logic [7:0]        al_en [4] = '{8'h41, 8'h41, 8'h01, 8'h00};
   logic [5:0]        al_mt [4] = '{6'h3e, 6'h01, 6'h3f, 6'h3f};
   logic [7:0]        al_ms [4] = '{8'h40, 8'h49, 8'h48, 8'h40};

   rtcc_control uut (.clk, .nrst, .cs_n, .rd_n, .wr_n, .addr, .data_in, .data_out, .data_oe,
      .rollover, .year_end, .compare_match, .compare_strobe, .power_loss_input, .standby,
      .osc_running, .osc_wave, .leap_count, .feb29_allowed, .hour_12_mode, .run_enable,
      .single_supply, .test_mode, .snapshot_track, .irq_out_n, .multi_function_output, .mfo_oe);
   rtcc_cpu_model cpu (.clk, .data_out, .data_oe, .cs_n, .rd_n, .wr_n, .addr, .data_in);

   // ------------------------------------------
   // Helpers
   // ------------------------------------------
   // Clock of 100 ns.
   always #50 clk = ~clk;

   function automatic logic [1:0] leap_next(input logic [1:0] v);
      return v + 2'h1;
   endfunction
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // A read is only trusted when the device also drove the bus.
   task automatic rdc(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
      cpu.rd(a, rv, oe);
      chk({7'h00, oe}, 8'h01);
      chk(rv, exp);
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic fire(input logic [5:0] m);
      @(posedge clk) rollover <= m;
      @(posedge clk) rollover <= 6'h00;
   endtask
   task automatic end_sim;
      $display("comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Watchdog: a hang is counted as a mismatch.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         err_count++;
         end_sim();
      end
   end

   // ------------------------------------------
   // Scenarios
   // ------------------------------------------
   initial begin
      void'($urandom(32'h140c));
      repeat (2) @(posedge clk);
      nrst <= 1'h1;
      rdc(OFF_ROLLOVER, 8'h40);
      cpu.wr(OFF_MAIN_STATUS, 8'h40);
      cpu.wr(OFF_RUN_CONTROL, 8'h08);
      rdc(OFF_RUN_CONTROL, 8'h00);
      osc_running <= 1'h1;
      cpu.wr(OFF_RUN_CONTROL, 8'h0c);
      rdc(OFF_RUN_CONTROL, 8'h0c);
      chk({6'h00, hour_12_mode, run_enable}, 8'h03);
      for (int i = 0; i < 6; i++) begin
         lp = (i == 0) ? 2'h3 : 2'($urandom);
         cpu.wr(OFF_RUN_CONTROL, {6'h03, lp});
         @(posedge clk) year_end <= 1'h1;
         @(posedge clk) year_end <= 1'h0;
         wait_n(0);
         lp = leap_next(lp);
         chk({5'h00, feb29_allowed, leap_count}, {5'h00, lp == 2'h0, lp});
      end
      cpu.wr(OFF_MAIN_STATUS, 8'h00);
      rdc(OFF_ROLLOVER, 8'h00);
      cpu.wr(OFF_ROLLOVER, 8'h00);
      wait_n(0);
      chk({7'h00, single_supply}, 8'h00);
      cpu.wr(OFF_SNAPSHOT, 8'hff);
      rdc(OFF_SNAPSHOT, 8'hbf);
      rdc(5'h02, 8'h00);
      for (int i = 0; i < 6; i++) begin
         cpu.wr(OFF_MAIN_STATUS, 8'h40);
         cpu.wr(OFF_PERIODIC_EN, 8'h01 << i);
         fire(6'h01 << i);
         wait_n(2);
         chk({7'h00, irq_out_n}, 8'h00);
         rdc(OFF_MAIN_STATUS, 8'h45);
         cpu.wr(OFF_MAIN_STATUS, 8'h04);
         rdc(OFF_ROLLOVER, 8'h01 << i);
         rdc(OFF_ROLLOVER, 8'h00);
      end
      cpu.wr(OFF_MAIN_STATUS, 8'h40);
      cpu.wr(OFF_PERIODIC_EN, 8'h00);
      fire(6'($urandom) | 6'h01);
      wait_n(3);
      rdc(OFF_MAIN_STATUS, 8'h40);
      rv = 8'($urandom);
      cpu.wr(OFF_OUTPUT_SELECT, {1'h0, rv[6:0]});
      rdc(OFF_OUTPUT_SELECT, {1'h0, rv[6:0]});
      // Alarm table; the last case clears every compare enable.
      for (int i = 0; i < 4; i++) begin
         cpu.wr(OFF_ALARM_PWR_EN, al_en[i]);
         @(posedge clk) compare_match <= al_mt[i];
         compare_strobe <= 1'h1;
         @(posedge clk) compare_strobe <= 1'h0;
         wait_n(3);
         chk({7'h00, irq_out_n}, {7'h00, ~al_ms[i][0]});
         rdc(OFF_MAIN_STATUS, al_ms[i]);
         cpu.wr(OFF_MAIN_STATUS, 8'h48);
      end
      cpu.wr(OFF_OUTPUT_SELECT, 8'h00);
      cpu.wr(OFF_ALARM_PWR_EN, 8'h80);
      @(posedge clk) power_loss_input <= 1'h1;
      wait_n(3);
      chk({6'h00, multi_function_output, snapshot_track}, 8'h00);
      rdc(OFF_MAIN_STATUS, 8'h43);
      cpu.wr(OFF_OUTPUT_SELECT, 8'h80);
      for (int i = 1; i >= 0; i--) begin
         @(posedge clk) osc_wave <= i[0];
         wait_n(2);
         chk({6'h00, multi_function_output, irq_out_n}, {6'h00, i[0], 1'h0});
      end
      @(posedge clk) power_loss_input <= 1'h0;
      wait_n(3);
      rdc(OFF_MAIN_STATUS, 8'h40);
      cpu.wr(OFF_ALARM_PWR_EN, 8'h00);
      osc_wave <= 1'h1;
      for (int s = 0; s < 2; s++) begin
         cpu.wr(OFF_RUN_CONTROL, {3'h0, s[0], 4'hc});
         cpu.wr(OFF_PERIODIC_EN, 8'h3f);
         @(posedge clk) standby <= 1'h1;
         wait_n(3);
         rdc(OFF_PERIODIC_EN, s[0] ? 8'h3f : 8'h00);
         @(posedge clk) standby <= 1'h0;
      end
      @(posedge clk) osc_running <= 1'h0;
      wait_n(2);
      chk({6'h00, run_enable, single_supply}, 8'h01);
      cpu.wr(OFF_MAIN_STATUS, 8'h00);
      rdc(OFF_ROLLOVER, 8'h40);
      chk({7'h00, test_mode}, 8'h00);
      // Battery-backed request is refused while the fail flag stands; test bit is stored.
      cpu.wr(OFF_ROLLOVER, 8'h80);
      wait_n(0);
      chk({6'h00, test_mode, single_supply}, 8'h03);
      rdc(OFF_ROLLOVER, 8'hc0);
      rdc(5'h1f, 8'h00);
      end_sim();
   end
endmodule

bind rtcc_control rtcc_control_checker chk_i (.clk, .nrst, .cs_n, .rd_n, .wr_n, .data_out,
   .data_oe, .year_end, .power_loss_input, .standby, .osc_running, .leap_count,
   .feb29_allowed, .run_enable, .snapshot_track, .multi_function_output, .mfo_oe);
